// File: rtl/elr_recorder.sv
// Event log recorder: detects status events, stores records and drives the log viewer.
// Assumes status sources on clk; buttons are asynchronous pins; registers on a plain port.
`timescale 1ns/10ps
`default_nettype none
module elr_recorder #(
  parameter int SEC_CYCLES = elr_pkg::CLK_FREQ_HZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire elr_pkg::elr_src_t src,
  input wire logic [1:0] pwd_level,
  input wire logic [7:0] fault_code,
  input wire logic [3:0] op_status,
  input wire logic [31:0] date_time,
  input wire logic [31:0] run_hours,
  input wire elr_pkg::elr_meas_t meas,
  input wire logic [elr_pkg::NUM_BTN-1:0] btn_pin,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic view_active,
  output logic [2:0] view_page,
  output elr_pkg::elr_rec_t view_record
);
  typedef struct packed {
    logic [elr_pkg::NUM_BTN-1:0] btn_s1;
    logic [elr_pkg::NUM_BTN-1:0] btn_s2;
    logic [elr_pkg::NUM_BTN-1:0] btn_s3;
    logic [elr_pkg::NUM_BTN-1:0] btn_stable;
    elr_pkg::elr_src_t prev;
    logic [elr_pkg::NUM_SRC-1:0] pending;
    logic [elr_pkg::NUM_SRC-1:0] enable;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rd_data;
    logic [31:0] tick_cnt;
    logic [11:0] sec_cnt;
    logic [31:0] event_num;
    logic [elr_pkg::LOG_AW-1:0] wr_ptr;
    logic [elr_pkg::LOG_AW:0] count;
    elr_pkg::elr_vstate_t vstate;
    logic [2:0] skip_cnt;
    logic [2:0] page;
    logic [elr_pkg::LOG_AW-1:0] age;
    logic wr_en;
    elr_pkg::elr_rec_t wr_rec;
  } elr_state_t;

  localparam elr_state_t RST_S = '{vstate: elr_pkg::VS_IDLE, enable: elr_pkg::ENABLE_RST,
                                   irq_mask: elr_pkg::IRQ_MASK_RST, default: '0};
  localparam logic [elr_pkg::LOG_AW:0] DEPTH_V = (elr_pkg::LOG_AW+1)'(elr_pkg::LOG_DEPTH);

  elr_state_t s;
  elr_state_t next_s;
  logic [elr_pkg::NUM_BTN-1:0] press;
  logic [elr_pkg::NUM_SRC-1:0] ev;
  logic [elr_pkg::NUM_SRC-1:0] pick;
  logic [3:0] pick_idx;
  logic sec_tick;
  logic [elr_pkg::LOG_AW-1:0] view_addr;
  elr_pkg::elr_rec_t mem [elr_pkg::LOG_DEPTH];

  always_comb begin
    next_s = s;
    next_s.wr_en = 1'b0;
    next_s.rd_data = 32'h0;
    pick = '0;
    pick_idx = 4'h0;
    // Button synchronisers: a change counts once the second and third stages agree.
    next_s.btn_s1 = btn_pin;
    next_s.btn_s2 = s.btn_s1;
    next_s.btn_s3 = s.btn_s2;
    for (int i = 0; i < elr_pkg::NUM_BTN; i++) begin
      if (s.btn_s2[i] == s.btn_s3[i]) begin
        next_s.btn_stable[i] = s.btn_s3[i];
      end
    end
    press = next_s.btn_stable & ~s.btn_stable;
    // Source edge detection.
    ev = '0;
    next_s.prev = src;
    ev[elr_pkg::EV_PROG] = src.prog_mode & ~s.prev.prog_mode;
    ev[elr_pkg::EV_MODE] = src.mode != s.prev.mode;
    ev[elr_pkg::EV_SHUTDOWN] = src.shutdown & ~s.prev.shutdown;
    ev[elr_pkg::EV_LOADDUMP] = src.loaddump & ~s.prev.loaddump;
    ev[elr_pkg::EV_WARNING] = src.warning & ~s.prev.warning;
    ev[elr_pkg::EV_MAINS_FAIL] = ~src.mains_ok & s.prev.mains_ok;
    ev[elr_pkg::EV_MAINS_RESTORE] = src.mains_ok & ~s.prev.mains_ok;
    ev[elr_pkg::EV_ENG_START] = src.engine_running & ~s.prev.engine_running;
    ev[elr_pkg::EV_ENG_STOP] = ~src.engine_running & s.prev.engine_running;
    ev[elr_pkg::EV_ON_LOAD] = src.on_load & ~s.prev.on_load;
    ev[elr_pkg::EV_OFF_LOAD] = ~src.on_load & s.prev.on_load;
    // Seconds divider and periodic timer.
    sec_tick = s.tick_cnt == 32'(SEC_CYCLES - 1);
    next_s.tick_cnt = sec_tick ? 32'h0 : s.tick_cnt + 32'h1;
    if (sec_tick) begin
      next_s.sec_cnt = s.sec_cnt + 12'h1;
      if ((src.engine_running && next_s.sec_cnt >= elr_pkg::PERIOD_RUN_SEC) ||
          next_s.sec_cnt >= elr_pkg::PERIOD_IDLE_SEC) begin
        ev[elr_pkg::EV_PERIODIC] = 1'b1;
        next_s.sec_cnt = 12'h0;
      end
    end
    // Store the lowest numbered pending event; a new event wins over the clear.
    for (int i = elr_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (s.pending[i]) begin
        pick = '0;
        pick[i] = 1'b1;
        pick_idx = 4'(i);
      end
    end
    next_s.pending = (s.pending & ~pick) | (ev & s.enable);
    if (s.pending != '0) begin
      next_s.wr_en = 1'b1;
      next_s.wr_rec.evnum = s.event_num;
      next_s.wr_rec.etype = pick_idx;
      next_s.wr_rec.fault_code = fault_code;
      next_s.wr_rec.pwd_level = pwd_level;
      next_s.wr_rec.date_time = date_time;
      next_s.wr_rec.mode = src.mode;
      next_s.wr_rec.status = op_status;
      next_s.wr_rec.run_hours = run_hours;
      next_s.wr_rec.meas = meas;
      next_s.event_num = s.event_num + 32'h1;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
      if (s.count != DEPTH_V) begin
        next_s.count = s.count + 1'b1;
      end
    end
    // Register port.
    if (reg_write) begin
      case (reg_addr)
        elr_pkg::REG_ENABLE: next_s.enable = reg_wdata[elr_pkg::NUM_SRC-1:0];
        elr_pkg::REG_IRQ_STATUS: next_s.irq_status = s.irq_status & ~reg_wdata[1:0];
        elr_pkg::REG_IRQ_MASK: next_s.irq_mask = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (s.pending != '0) begin
      next_s.irq_status[elr_pkg::IRQ_STORED] = 1'b1;
      if (s.count == DEPTH_V) begin
        next_s.irq_status[elr_pkg::IRQ_OVERWRITE] = 1'b1;
      end
    end
    if (reg_read) begin
      case (reg_addr)
        elr_pkg::REG_ENABLE: next_s.rd_data = 32'(s.enable);
        elr_pkg::REG_IRQ_STATUS: next_s.rd_data = 32'(s.irq_status);
        elr_pkg::REG_IRQ_MASK: next_s.rd_data = 32'(s.irq_mask);
        elr_pkg::REG_EVENT_NUM: next_s.rd_data = s.event_num;
        elr_pkg::REG_LOG_COUNT: next_s.rd_data = 32'(s.count);
        elr_pkg::REG_VIEW: next_s.rd_data = {12'h0, s.vstate, 4'(s.skip_cnt),
                                             s.age, s.page};
        default: next_s.rd_data = 32'h0;
      endcase
    end
    // Viewer, reachable only while programming mode is active.
    case (s.vstate)
      elr_pkg::VS_IDLE: begin
        if (src.prog_mode) begin
          next_s.vstate = elr_pkg::VS_PWD;
          next_s.skip_cnt = 3'h0;
        end
      end
      elr_pkg::VS_PWD: begin
        if (press[elr_pkg::BTN_SKIP]) begin
          next_s.skip_cnt = s.skip_cnt + 3'h1;
          if (s.skip_cnt == 3'(elr_pkg::SKIP_PRESSES - 1)) begin
            next_s.vstate = elr_pkg::VS_MENU;
          end
        end
      end
      elr_pkg::VS_MENU: begin
        if (press[elr_pkg::BTN_SKIP]) begin
          next_s.vstate = elr_pkg::VS_VIEW;
          next_s.age = '0;
          next_s.page = 3'h0;
        end
      end
      elr_pkg::VS_VIEW: begin
        if (press[elr_pkg::BTN_NEXT_PAGE]) begin
          next_s.page = (s.page == 3'(elr_pkg::NUM_PAGES - 1)) ? 3'h0 : s.page + 3'h1;
        end else if (press[elr_pkg::BTN_PREV_PAGE]) begin
          next_s.page = (s.page == 3'h0) ? 3'(elr_pkg::NUM_PAGES - 1) : s.page - 3'h1;
        end else if (press[elr_pkg::BTN_PREV_EVENT]) begin
          if ((elr_pkg::LOG_AW+1)'(s.age) + 1'b1 < s.count) begin
            next_s.age = s.age + 1'b1;
          end
        end else if (press[elr_pkg::BTN_NEXT_EVENT]) begin
          if (s.age != '0) begin
            next_s.age = s.age - 1'b1;
          end
        end
      end
      default: next_s.vstate = elr_pkg::VS_IDLE;
    endcase
    if (!src.prog_mode) begin
      next_s.vstate = elr_pkg::VS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign view_addr = s.wr_ptr - s.age - 1'b1;

  // Record memory and its registered read port for the display.
  always_ff @(posedge clk) begin
    if (s.wr_en) begin
      mem[s.wr_ptr - 1'b1] <= s.wr_rec;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      view_record <= '0;
    end else begin
      view_record <= mem[view_addr];
    end
  end

  assign reg_rdata = s.rd_data;
  assign irq = |(s.irq_status & s.irq_mask);
  assign view_active = (s.vstate == elr_pkg::VS_VIEW) && (s.count != '0);
  assign view_page = s.page;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence q_mains_drop;
    s.prev.mains_ok && !src.mains_ok && s.enable[elr_pkg::EV_MAINS_FAIL];
  endsequence
  sequence q_open;
    s.vstate == elr_pkg::VS_MENU && press[elr_pkg::BTN_SKIP] && src.prog_mode;
  endsequence

  property p_store;
    s.pending != '0 |=> s.wr_en && s.wr_rec.evnum + 32'h1 == s.event_num;
  endproperty
  a_store: assert property (p_store) else $error("Pending event not stored.");
  property p_disabled;
    ((s.pending & ~$past(s.pending)) & ~$past(s.enable)) == '0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Disabled source queued.");
  property p_prog;
    src.prog_mode && !s.prev.prog_mode && s.enable[elr_pkg::EV_PROG]
      |=> s.pending[elr_pkg::EV_PROG];
  endproperty
  a_prog: assert property (p_prog) else $error("Programming entry not queued.");
  property p_periodic;
    $rose(s.pending[elr_pkg::EV_PERIODIC]) |-> s.sec_cnt == 12'h0;
  endproperty
  a_periodic: assert property (p_periodic) else $error("Periodic event off its timer.");
  property p_mode;
    src.mode != s.prev.mode && s.enable[elr_pkg::EV_MODE] |=> s.pending[elr_pkg::EV_MODE];
  endproperty
  a_mode: assert property (p_mode) else $error("Mode change not queued.");
  property p_mains;
    q_mains_drop |=> s.pending[elr_pkg::EV_MAINS_FAIL] ##1 s.wr_en;
  endproperty
  a_mains: assert property (p_mains) else $error("Mains fail not recorded.");
  property p_view_prog;
    view_active |-> $past(src.prog_mode);
  endproperty
  a_view_prog: assert property (p_view_prog) else $error("Log shown outside programming.");
  property p_open;
    q_open |=> s.vstate == elr_pkg::VS_VIEW && s.age == '0 && s.page == 3'h0;
  endproperty
  a_open: assert property (p_open) else $error("Log did not open on newest.");
  property p_next_event;
    s.vstate == elr_pkg::VS_VIEW && src.prog_mode && press[elr_pkg::BTN_NEXT_EVENT]
      && !press[elr_pkg::BTN_NEXT_PAGE] && !press[elr_pkg::BTN_PREV_PAGE]
      && !press[elr_pkg::BTN_PREV_EVENT] |=> $stable(s.page);
  endproperty
  a_next_event: assert property (p_next_event) else $error("Page lost on event step.");
  property p_wrap;
    s.pending != '0 && s.wr_ptr == '1 |=> s.wr_ptr == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Write pointer did not wrap.");
endmodule : elr_recorder
`default_nettype wire

// File: include/elr_pkg.sv
// Package of the event log recorder: constants, record layout and state encodings.
// Assumes a 250 MHz system clock and a plain register port with a 4-bit word address.
package elr_pkg;
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int LOG_DEPTH = 512;
  localparam int LOG_AW = 9;
  localparam int NUM_SRC = 12;
  localparam int NUM_BTN = 5;
  localparam int NUM_PAGES = 6;
  localparam int NUM_MEAS = 22;
  localparam int SKIP_PRESSES = 4;
  localparam int PERIOD_RUN_MIN = 30;
  localparam int PERIOD_IDLE_MIN = 60;
  localparam logic [11:0] PERIOD_RUN_SEC = 12'(PERIOD_RUN_MIN * 60);
  localparam logic [11:0] PERIOD_IDLE_SEC = 12'(PERIOD_IDLE_MIN * 60);
  // Event source numbers, also the stored event type code and the enable bit index.
  localparam int EV_PROG = 0;
  localparam int EV_PERIODIC = 1;
  localparam int EV_MODE = 2;
  localparam int EV_SHUTDOWN = 3;
  localparam int EV_LOADDUMP = 4;
  localparam int EV_WARNING = 5;
  localparam int EV_MAINS_FAIL = 6;
  localparam int EV_MAINS_RESTORE = 7;
  localparam int EV_ENG_START = 8;
  localparam int EV_ENG_STOP = 9;
  localparam int EV_ON_LOAD = 10;
  localparam int EV_OFF_LOAD = 11;
  // Button positions in the button vector.
  localparam int BTN_NEXT_PAGE = 0;
  localparam int BTN_PREV_PAGE = 1;
  localparam int BTN_PREV_EVENT = 2;
  localparam int BTN_NEXT_EVENT = 3;
  localparam int BTN_SKIP = 4;
  // Register word addresses.
  localparam logic [3:0] REG_ENABLE = 4'h0;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_MASK = 4'h2;
  localparam logic [3:0] REG_EVENT_NUM = 4'h3;
  localparam logic [3:0] REG_LOG_COUNT = 4'h4;
  localparam logic [3:0] REG_VIEW = 4'h5;
  localparam logic [11:0] ENABLE_RST = 12'hFFF;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam int IRQ_STORED = 0;
  localparam int IRQ_OVERWRITE = 1;

  typedef enum logic [3:0] {
    VS_IDLE = 4'h1,
    VS_PWD = 4'h2,
    VS_MENU = 4'h4,
    VS_VIEW = 4'h8
  } elr_vstate_t;

  typedef logic [NUM_MEAS-1:0][15:0] elr_meas_t;

  typedef struct packed {
    logic [31:0] evnum;
    logic [3:0] etype;
    logic [7:0] fault_code;
    logic [1:0] pwd_level;
    logic [31:0] date_time;
    logic [2:0] mode;
    logic [3:0] status;
    logic [31:0] run_hours;
    elr_meas_t meas;
  } elr_rec_t;

  typedef struct packed {
    logic [2:0] mode;
    logic engine_running;
    logic mains_ok;
    logic on_load;
    logic shutdown;
    logic loaddump;
    logic warning;
    logic prog_mode;
  } elr_src_t;
endpackage : elr_pkg

// File: verification/elr_panel_model.sv
// Front panel operator model: turns one-cycle press requests into held button levels.
// Assumes requests arrive at least 20 clk cycles apart and buttons pull down when released.
`timescale 1ns/10ps
`default_nettype none
module elr_panel_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] press,
  output logic [4:0] btn_pin
);
  logic [3:0] hold;
  // A press is held for 8 cycles, then the pin falls to its pulled-down level.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 4'h0;
      btn_pin <= 5'h00;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
      if (hold == 4'h1) begin
        btn_pin <= 5'h00;
      end
    end else if (press != 5'h00) begin
      hold <= 4'h8;
      btn_pin <= press;
    end
  end
endmodule : elr_panel_model
`default_nettype wire

// File: verification/elr_recorder_tb_top.sv
// Self-checking bench of the event log recorder with a panel operator model.
// Assumes a 4 ns clock and a one-second tick shortened to 10 cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module elr_recorder_tb_top;
  localparam int SEC = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  elr_pkg::elr_src_t src = '0;
  elr_pkg::elr_src_t s;
  logic [1:0] pwd_level = 2'h0;
  logic [7:0] fault_code = 8'h00;
  logic [3:0] op_status = 4'h0;
  logic [31:0] date_time = 32'h0;
  logic [31:0] run_hours = 32'h0;
  elr_pkg::elr_meas_t meas = '0;
  logic [4:0] press = 5'h00;
  logic [4:0] btn_pin;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic view_active;
  logic [2:0] view_page;
  elr_pkg::elr_rec_t view_record;
  int bad_count = 0;
  int tests_run = 0;
  int seed;
  int n;
  logic [31:0] v;
  logic [31:0] exp_num = 32'h0;
  logic [11:0] en;

  elr_recorder #(.SEC_CYCLES(SEC)) elr_recorder_inst (.clk(clk), .reset_n(reset_n), .src(src),
    .pwd_level(pwd_level), .fault_code(fault_code), .op_status(op_status),
    .date_time(date_time), .run_hours(run_hours), .meas(meas), .btn_pin(btn_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .view_active(view_active), .view_page(view_page),
    .view_record(view_record));
  elr_panel_model elr_panel_model_inst (.clk(clk), .reset_n(reset_n), .press(press),
    .btn_pin(btn_pin));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Applies a source state and checks the event number grew by the expected amount.
  task automatic ev(input elr_pkg::elr_src_t ns, input logic d);
    @(posedge clk);
    src <= ns;
    repeat (6) @(posedge clk);
    exp_num = exp_num + 32'(d);
    rd(elr_pkg::REG_EVENT_NUM, v);
    `CHK(v, exp_num)
  endtask : ev

  task automatic push(input int b);
    @(posedge clk);
    press <= 5'(1 << b);
    @(posedge clk);
    press <= 5'h00;
    repeat (20) @(posedge clk);
  endtask : push

  // Polls the event number until it moves and returns the cycles spent.
  task automatic wait_ev(output int c);
    c = 0;
    v = exp_num;
    while (v === exp_num && c < 40000) begin
      rd(elr_pkg::REG_EVENT_NUM, v);
      c = c + 2;
    end
    if (v === exp_num) begin
      bad_count++;
    end
    exp_num = exp_num + 32'h1;
  endtask : wait_ev

  function automatic int period_cycles(input logic running);
    return (running ? elr_pkg::PERIOD_RUN_MIN : elr_pkg::PERIOD_IDLE_MIN) * 60 * SEC;
  endfunction : period_cycles

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    seed = 32'h6d0cd135;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(elr_pkg::REG_ENABLE, v);
    `CHK(v, 32'h00000FFF)
    rd(elr_pkg::REG_LOG_COUNT, v);
    `CHK(v, 32'h0)
    rd(4'hF, v);
    `CHK(v, 32'h0)
    $display("test reset done");
    wr(elr_pkg::REG_ENABLE, 32'h00000FFD);
    wr(elr_pkg::REG_IRQ_MASK, 32'h1);
    s = src;
    s.mains_ok = 1'b1;
    ev(s, 1'b1);
    s.mains_ok = 1'b0;
    ev(s, 1'b1);
    s.engine_running = 1'b1;
    ev(s, 1'b1);
    s.engine_running = 1'b0;
    ev(s, 1'b1);
    s.on_load = 1'b1;
    ev(s, 1'b1);
    s.on_load = 1'b0;
    ev(s, 1'b1);
    s.shutdown = 1'b1;
    ev(s, 1'b1);
    s.loaddump = 1'b1;
    ev(s, 1'b1);
    s.warning = 1'b1;
    ev(s, 1'b1);
    `CHK(irq, 1'b1)
    wr(elr_pkg::REG_IRQ_STATUS, 32'h1);
    #1;
    `CHK(irq, 1'b0)
    for (int i = 0; i < 8; i++) begin
      en = 12'($random(seed)) & 12'hFFD;
      wr(elr_pkg::REG_ENABLE, {20'h0, en});
      s.mode = s.mode + 3'h1 + 3'($random(seed) & 1);
      ev(s, en[elr_pkg::EV_MODE]);
    end
    $display("test sources done");
    wr(elr_pkg::REG_ENABLE, 32'h000000C0);
    for (int i = 0; i < 520; i++) begin
      s.mains_ok = ~s.mains_ok;
      ev(s, 1'b1);
    end
    rd(elr_pkg::REG_LOG_COUNT, v);
    `CHK(v, 32'd512)
    rd(elr_pkg::REG_IRQ_STATUS, v);
    `CHK(v[elr_pkg::IRQ_OVERWRITE], 1'b1)
    $display("test overwrite done");
    wr(elr_pkg::REG_ENABLE, 32'h00000001);
    date_time <= $random(seed);
    run_hours <= $random(seed);
    pwd_level <= 2'h2;
    s.prog_mode = 1'b1;
    ev(s, 1'b1);
    repeat (4) push(elr_pkg::BTN_SKIP);
    rd(elr_pkg::REG_VIEW, v);
    `CHK(v[19:16], 4'h4)
    `CHK(view_active, 1'b0)
    push(elr_pkg::BTN_SKIP);
    `CHK(view_active, 1'b1)
    `CHK(view_page, 3'h0)
    `CHK(view_record.evnum, exp_num - 32'h1)
    `CHK(view_record.etype, 4'(elr_pkg::EV_PROG))
    `CHK(view_record.pwd_level, 2'h2)
    `CHK(view_record.date_time, date_time)
    `CHK(view_record.run_hours, run_hours)
    push(elr_pkg::BTN_NEXT_PAGE);
    `CHK(view_page, 3'h1)
    push(elr_pkg::BTN_PREV_PAGE);
    push(elr_pkg::BTN_PREV_PAGE);
    `CHK(view_page, 3'h5)
    push(elr_pkg::BTN_PREV_EVENT);
    `CHK(view_record.evnum, exp_num - 32'h2)
    `CHK(view_page, 3'h5)
    push(elr_pkg::BTN_NEXT_EVENT);
    `CHK(view_record.evnum, exp_num - 32'h1)
    s.prog_mode = 1'b0;
    ev(s, 1'b0);
    `CHK(view_active, 1'b0)
    $display("test viewer done");
    wr(elr_pkg::REG_ENABLE, 32'h00000002);
    s.engine_running = 1'b1;
    ev(s, 1'b0);
    wait_ev(n);
    wait_ev(n);
    `CHK(n >= period_cycles(1'b1) - 10 && n <= period_cycles(1'b1) + 10, 1'b1)
    s.engine_running = 1'b0;
    @(posedge clk);
    src <= s;
    wait_ev(n);
    `CHK(n >= period_cycles(1'b0) - 20 && n <= period_cycles(1'b0) + 10, 1'b1)
    $display("test periodic done");
    close_out();
  end
endmodule : elr_recorder_tb_top
`default_nettype wire
